// ===== hdl/adcsq_ctrl.sv
// Notes on behaviour
// - Sequence length from code; zero means sixteen
// - Freeze with selection zero keeps converting
// - Freeze selection 10: finish conversion, then halt
// - 8-bit left: bits 11..4, low zeros
// - 8-bit right: bits 7..0, high zeros
// - 10-bit left: bits 11..2, low zeros
// - 10-bit right: bits 9..0, high zeros
// - 12-bit fills all twelve bits
// - One of sixteen channels to sample stage
// - Resolution selectable 8, 10 or 12
// - Binary search, one bit per step, MSB first
// - Converter powered only while converting
// - Sample connects input, hold disconnects it
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module adcsq_ctrl
   import adcsq_pkg::*;
#(
   parameter int SAMPLE_CYC = ADCSQ_SAMPLE_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic debug_freeze,
   input wire logic comp_above,
   output adcsq_afe_t afe,
   output logic seq_done
);
   // Sample counter is eight bits; zero would leave sampling after one cycle, same as one
   if (SAMPLE_CYC < 1 || SAMPLE_CYC > 255)
      $error("SAMPLE_CYC out of range");

   // Left or right justification and padding of a raw SAR value
   function automatic logic [11:0] map_res(input logic [11:0] v,
      input logic [1:0] res, input logic rj);
      logic [11:0] o;
      o = v;
      if (res == ADCSQ_RES8)
         o = rj ? {4'h0, v[11:4]} : {v[11:4], 4'h0};
      else if (res == ADCSQ_RES10)
         o = rj ? {2'h0, v[11:2]} : {v[11:2], 2'h0};
      return o;
   endfunction

   function automatic logic [3:0] last_bit(input logic [1:0] res);
      logic [3:0] b;
      b = 4'h0;
      if (res == ADCSQ_RES8)
         b = 4'h4;
      else if (res == ADCSQ_RES10)
         b = 4'h2;
      return b;
   endfunction

   logic [31:0] ctrl_r, ctrl_nxt;
   logic [11:0] res_r [ADCSQ_NUM_RES];
   logic [11:0] res_nxt [ADCSQ_NUM_RES];
   adcsq_state_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [11:0] sar_r, sar_nxt;
   logic [4:0] conv_r, conv_nxt;
   logic [3:0] ch_r, ch_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic aw_r, aw_nxt, w_r, w_nxt;
   logic [7:0] awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic bv_r, bv_nxt, rv_r, rv_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   logic [1:0] res_sel;
   logic rj;
   logic [3:0] len_code;
   logic [4:0] seq_len;
   logic frz_halt;
   logic start_wr;

   assign res_sel = ctrl_r[ADCSQ_CTL_RES_LO +: 2];
   assign rj = ctrl_r[ADCSQ_CTL_RJ];
   assign len_code = ctrl_r[ADCSQ_CTL_LEN_LO +: 4];
   assign seq_len = (len_code == 4'h0) ? 5'h10 : {1'b0, len_code};
   // Only 10 stalls; 00 runs on, 01 reserved and treated as 00
   assign frz_halt = debug_freeze && ctrl_r[ADCSQ_CTL_FRZ_HI]
      && !ctrl_r[ADCSQ_CTL_FRZ_LO];

   // AXI handshakes: accept each channel once, answer after both
   assign s_axi_awready = !aw_r && !bv_r;
   assign s_axi_wready = !w_r && !bv_r;
   assign s_axi_arready = !rv_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign seq_done = done_r;

   // Write decode and read mux
   always_comb
   begin
      logic [7:0] a;
      logic [31:0] d;
      a = 8'h00;
      d = 32'h0;
      aw_nxt = aw_r;
      w_nxt = w_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      bv_nxt = bv_r;
      bresp_nxt = bresp_r;
      rv_nxt = rv_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      ctrl_nxt = ctrl_r;
      start_wr = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
         for (int i = 0; i < 4; i++)
            if (s_axi_wstrb[i])
               wd_nxt[i*8 +: 8] = s_axi_wdata[i*8 +: 8];
            else
               wd_nxt[i*8 +: 8] = ctrl_r[i*8 +: 8];
      end
      if (aw_r && w_r)
      begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         bv_nxt = 1'b1;
         bresp_nxt = ADCSQ_OKAY;
         if (awa_r[7:2] == ADCSQ_CTRL_OFF[7:2])
         begin
            ctrl_nxt = wd_r;
            ctrl_nxt[ADCSQ_CTL_START] = 1'b0; // Start self-clears
            start_wr = wd_r[ADCSQ_CTL_START];
         end
         else if (awa_r[7:2] == ADCSQ_STAT_OFF[7:2]
            || awa_r[7:6] == ADCSQ_RES_BASE[7:6])
            bresp_nxt = ADCSQ_OKAY; // Read-only, write ignored
         else
            bresp_nxt = ADCSQ_SLVERR;
      end
      if (bv_r && s_axi_bready)
         bv_nxt = 1'b0;
      if (rv_r && s_axi_rready)
         rv_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         a = s_axi_araddr;
         rv_nxt = 1'b1;
         rresp_nxt = ADCSQ_OKAY;
         if (a[7:2] == ADCSQ_CTRL_OFF[7:2])
            d = ctrl_r;
         else if (a[7:2] == ADCSQ_STAT_OFF[7:2])
            d = {22'h0, conv_r, done_r, busy_r, frz_halt, 2'h0};
         else if (a[7:6] == ADCSQ_RES_BASE[7:6])
            d = {20'h0, res_r[a[5:2]]};
         else
            rresp_nxt = ADCSQ_SLVERR;
         rdata_nxt = d;
      end
   end

   // Conversion sequencer
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      sar_nxt = sar_r;
      conv_nxt = conv_r;
      ch_nxt = ch_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      res_nxt = res_r;
      if (start_wr)
         done_nxt = 1'b0;
      case (st_r)
         ADCSQ_IDLE:
         begin
            if (start_wr)
            begin
               busy_nxt = 1'b1;
               conv_nxt = 5'h0;
               ch_nxt = ctrl_nxt[ADCSQ_CTL_CH_LO +: 4];
               cnt_nxt = 8'(ADCSQ_PWRUP_CYC);
               st_nxt = ADCSQ_PWRUP;
            end
         end
         ADCSQ_PWRUP:
         begin
            if (cnt_r <= 8'h1)
            begin
               cnt_nxt = 8'(SAMPLE_CYC);
               st_nxt = ADCSQ_SAMPLE;
            end
            else
               cnt_nxt = cnt_r - 8'h1;
         end
         ADCSQ_SAMPLE:
         begin
            // Freeze only acts between conversions
            if (frz_halt)
               st_nxt = ADCSQ_SAMPLE;
            else if (cnt_r <= 8'h1)
               st_nxt = ADCSQ_HOLD;
            else
               cnt_nxt = cnt_r - 8'h1;
         end
         ADCSQ_HOLD:
         begin
            bit_nxt = 4'hb;
            sar_nxt = 12'h800;
            st_nxt = ADCSQ_SAR;
         end
         ADCSQ_SAR:
         begin
            if (!comp_above)
               sar_nxt[bit_r] = 1'b0;
            if (bit_r != last_bit(res_sel))
            begin
               bit_nxt = bit_r - 4'h1;
               sar_nxt[bit_r - 4'h1] = 1'b1;
            end
            else
               st_nxt = ADCSQ_STORE;
         end
         ADCSQ_STORE:
         begin
            res_nxt[conv_r[3:0]] = map_res(sar_r, res_sel, rj);
            conv_nxt = conv_r + 5'h1;
            ch_nxt = ch_r + 4'h1;
            if (conv_r + 5'h1 == seq_len)
            begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               st_nxt = ADCSQ_IDLE;
            end
            else
            begin
               cnt_nxt = 8'(SAMPLE_CYC);
               st_nxt = ADCSQ_SAMPLE;
            end
         end
         default:
            st_nxt = ADCSQ_IDLE;
      endcase
   end

   // Front end drive: power only outside idle, one channel
   always_comb
   begin
      afe.pwr_on = (st_r != ADCSQ_IDLE);
      afe.sample = (st_r == ADCSQ_SAMPLE);
      afe.chan = ch_r;
      afe.dac = sar_r;
   end

   // State registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r <= ADCSQ_CTL_RST;
         st_r <= ADCSQ_IDLE;
         cnt_r <= 8'h0;
         bit_r <= 4'h0;
         sar_r <= 12'h000;
         conv_r <= 5'h0;
         ch_r <= 4'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         aw_r <= 1'b0;
         w_r <= 1'b0;
         awa_r <= 8'h00;
         wd_r <= 32'h0;
         bv_r <= 1'b0;
         rv_r <= 1'b0;
         bresp_r <= 2'h0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0;
         for (int i = 0; i < ADCSQ_NUM_RES; i++)
            res_r[i] <= 12'h000;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         sar_r <= sar_nxt;
         conv_r <= conv_nxt;
         ch_r <= ch_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         aw_r <= aw_nxt;
         w_r <= w_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         bv_r <= bv_nxt;
         rv_r <= rv_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         res_r <= res_nxt;
      end
   end
endmodule

// ===== hdl/adcsq_pkg.sv
package adcsq_pkg;
   // Register byte offsets
   localparam logic [7:0] ADCSQ_CTRL_OFF = 8'h00;
   localparam logic [7:0] ADCSQ_STAT_OFF = 8'h04;
   localparam logic [7:0] ADCSQ_RES_BASE = 8'h40;
   localparam int ADCSQ_NUM_RES = 16;
   localparam int ADCSQ_NUM_CH = 16;
   // Control register field positions
   localparam int ADCSQ_CTL_START = 0;
   localparam int ADCSQ_CTL_RJ = 1;
   localparam int ADCSQ_CTL_RES_LO = 2;
   localparam int ADCSQ_CTL_FRZ_LO = 4;
   localparam int ADCSQ_CTL_FRZ_HI = 5;
   localparam int ADCSQ_CTL_LEN_LO = 8;
   localparam int ADCSQ_CTL_CH_LO = 12;
   localparam logic [31:0] ADCSQ_CTL_RST = 32'h0000_0000;
   // Resolution codes
   localparam logic [1:0] ADCSQ_RES8 = 2'h0;
   localparam logic [1:0] ADCSQ_RES10 = 2'h1;
   localparam logic [1:0] ADCSQ_RES12 = 2'h2;
   // Timing in clock cycles
   localparam int ADCSQ_SAMPLE_CYC = 4;
   localparam int ADCSQ_PWRUP_CYC = 2;
   // AXI responses
   localparam logic [1:0] ADCSQ_OKAY = 2'h0;
   localparam logic [1:0] ADCSQ_SLVERR = 2'h2;

   typedef enum {ADCSQ_IDLE, ADCSQ_PWRUP, ADCSQ_SAMPLE, ADCSQ_HOLD,
      ADCSQ_SAR, ADCSQ_STORE} adcsq_state_t;

   // Analog front end control bundle
   typedef struct packed {
      logic pwr_on;
      logic sample;
      logic [3:0] chan;
      logic [11:0] dac;
   } adcsq_afe_t;
endpackage

// ===== bench/adcsq_ctrl_chk.sv
`timescale 1ns/1ps
module adcsq_ctrl_chk
   import adcsq_pkg::*;
#(
   parameter int SAMPLE_CYC = ADCSQ_SAMPLE_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input adcsq_afe_t afe,
   input wire logic seq_done
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Power-up settle must pass before the input is connected
   sequence pwrup_then_sample;
      !afe.sample [*2] ##1 afe.sample;
   endsequence
   // Held channel must not move for the eight cycles after hold, the whole 8-bit search
   sequence chan_held;
      ##1 $stable(afe.chan) [*8];
   endsequence

   chk_pwrup_wait: assert property
      ($rose(afe.pwr_on) |-> pwrup_then_sample)
      else $error("sample phase not two cycles after power up");
   chk_sample_pwr: assert property (afe.sample |-> afe.pwr_on)
      else $error("sampling while powered down");
   chk_hold_chan: assert property ($fell(afe.sample) |-> chan_held)
      else $error("channel moved during hold or search");
   chk_done_idle: assert property ($rose(seq_done) |-> !afe.pwr_on)
      else $error("done raised while converter powered");
   chk_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read data late");
   chk_wr_gate: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_rd_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
endmodule

bind adcsq_ctrl adcsq_ctrl_chk #(.SAMPLE_CYC(SAMPLE_CYC)) chk_i (.*);

// ===== bench/adcsq_afe_model.sv
`timescale 1ns/1ps
module adcsq_afe_model
   import adcsq_pkg::*;
(
   input wire logic aclk,
   input adcsq_afe_t afe,
   output logic comp_above
);
   logic [11:0] held_r = 12'h000;
   logic junk_r = 1'b0;
   // Storage node tracks the routed input only while sampling
   always_ff @(posedge aclk)
   begin
      if (afe.sample)
         held_r <= {afe.chan, ~afe.chan, 4'h9};
      junk_r <= ~junk_r;
   end
   // Comparator output is meaningless unless powered and holding
   assign comp_above = (afe.pwr_on && !afe.sample) ? (held_r >= afe.dac)
      : junk_r;
endmodule

// ===== bench/adc_sequence_result_control_tb_top.sv
`timescale 1ns/1ps
module adc_sequence_result_control_tb_top;
   import adcsq_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, debug_freeze = 1'b0, comp_above;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, seq_done;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   adcsq_afe_t afe;
   int mismatches = 0, num_checks = 0, cycles = 0;

   always #20 aclk = ~aclk;

   adcsq_ctrl #(.SAMPLE_CYC(1)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .debug_freeze(debug_freeze), .comp_above(comp_above), .afe(afe),
      .seq_done(seq_done));
   adcsq_afe_model afe_i (.aclk(aclk), .afe(afe), .comp_above(comp_above));

   task tally_and_finish;
      if (mismatches == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard, well above the longest expected run
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         tally_and_finish;
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %0t %s got %h want %h", $time, m, seen, exp);
      end
   endtask

   task axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Same level table as the front end model, scaled to the search width
   function logic [31:0] exp_res(input logic [3:0] c, input logic [1:0] res,
      input logic rj);
      logic [11:0] v;
      v = {c, ~c, 4'h9};
      if (res == ADCSQ_RES8)
         exp_res = rj ? {24'h0, v[11:4]} : {20'h0, v[11:4], 4'h0};
      else if (res == ADCSQ_RES10)
         exp_res = rj ? {22'h0, v[11:2]} : {20'h0, v[11:2], 2'h0};
      else
         exp_res = {20'h0, v};
   endfunction

   task run_seq(input logic [3:0] ch, input logic [3:0] len,
      input logic [1:0] res, input logic rj, input logic [1:0] frz,
      input logic frz_on);
      int n;
      logic [31:0] d;
      logic [1:0] r;
      n = (len == 4'h0) ? 16 : int'(len);
      debug_freeze <= frz_on;
      axi_wr(ADCSQ_CTRL_OFF, {16'h0, ch, len, 2'h0, frz, res, rj, 1'b1}, r);
      if (frz == 2'b10)
      begin
         repeat (200) @(posedge aclk);
         check(32'(seq_done), 32'h0, "halted");
         axi_rd(ADCSQ_STAT_OFF, d, r);
         check(32'(d[2]), 32'h1, "frozen flag");
         debug_freeze <= 1'b0;
      end
      for (int k = 0; k < 3000 && seq_done !== 1'b1; k++)
         @(posedge aclk);
      check(32'(seq_done), 32'h1, "sequence done");
      check(32'(afe.pwr_on), 32'h0, "idle power down");
      debug_freeze <= 1'b0;
      axi_rd(ADCSQ_STAT_OFF, d, r);
      check(32'(d[9:4]), {26'h0, 5'(n), 1'b1}, "conversion count");
      for (int i = 0; i < n; i++)
      begin
         axi_rd(ADCSQ_RES_BASE + 8'(4 * i), d, r);
         check(d, exp_res(ch + 4'(i), res, rj), "result");
      end
   endtask

   task s_regs;
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(ADCSQ_CTRL_OFF, d, r);
      check(d, ADCSQ_CTL_RST, "ctrl reset");
      axi_rd(8'h20, d, r);
      check(32'(r), 32'(ADCSQ_SLVERR), "unmapped read");
      axi_wr(8'h30, 32'hffff_ffff, r);
      check(32'(r), 32'(ADCSQ_SLVERR), "unmapped write");
      axi_wr(ADCSQ_RES_BASE, 32'hffff_ffff, r);
      check(32'(r), 32'(ADCSQ_OKAY), "result write ignored");
   endtask

   // Every resolution in both justifications, one conversion each
   task s_map;
      for (int m = 0; m < 6; m++)
         run_seq(4'(m * 5), 4'h1, 2'(m / 2),
            1'(m % 2), 2'b00, 1'b0);
   endtask

   task s_len;
      run_seq(4'hd, 4'h0, ADCSQ_RES12, 1'b0, 2'b00, 1'b0);
      run_seq(4'h2, 4'hf, ADCSQ_RES10, 1'b1, 2'b00, 1'b0);
   endtask

   task s_freeze;
      run_seq(4'h3, 4'h2, ADCSQ_RES8, 1'b0, 2'b10, 1'b1);
      run_seq(4'h7, 4'h3, ADCSQ_RES12, 1'b1, 2'b00, 1'b1);
   endtask

   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      s_regs;
      s_map;
      s_len;
      s_freeze;
      tally_and_finish;
   end
endmodule
